// >>> slsl_params.svh
// Constants for the status lamp block: register map, fields, timing.
// Included by the package and the lamp module; holds definitions only.
`ifndef SLSL_PARAMS_SVH
`define SLSL_PARAMS_SVH

`define SLSL_CLK_HZ 20000000
`define SLSL_FAST_HALF_MS 100
`define SLSL_SLOW_RATIO 4
`define SLSL_FAST_HALF_CYC (`SLSL_FAST_HALF_MS * (`SLSL_CLK_HZ / 1000))

`define SLSL_SETUP_BLOCK_ID 8'hff

`define SLSL_ADDR_W 8
`define SLSL_OFS_CTRL 8'h00
`define SLSL_OFS_STATUS 8'h04
`define SLSL_OFS_INPUTS 8'h08

`define SLSL_CTRL_VARIANT 0
`define SLSL_CTRL_LAMP_TEST 1
`define SLSL_CTRL_RESET 2'h0

`define SLSL_ST_HEALTH 0
`define SLSL_ST_FAULT 1
`define SLSL_ST_SETUP 2
`define SLSL_ST_BPLANE 3
`define SLSL_ST_PERR 4
`define SLSL_ST_SEND 6
`define SLSL_ST_RECV 8
`define SLSL_ST_TRAF 10

`define SLSL_IN_CTS 0

`endif

// >>> slsl_pkg.sv
// Types shared by the status lamp block.
// Assumes slsl_params.svh sits in the same folder.
`include "slsl_params.svh"

package slsl_pkg;
  typedef enum logic {
    SLSL_VAR_SPLIT,
    SLSL_VAR_COMBINED
  } slsl_variant_e;

  typedef enum logic [1:0] {
    SLSL_SETUP_IDLE,
    SLSL_SETUP_ARM,
    SLSL_SETUP_ON,
    SLSL_SETUP_OFF
  } slsl_setup_e;

  typedef logic [1:0] slsl_port_t;
endpackage

// >>> slsl_lamps.sv
// Front panel status lamp driver for a two-port serial module, with APB registers.
// Assumes status inputs come from logic on pclk; the CTS pins come from outside.
// How it works
// R1 - Health lamp blinks fast while transfers with the host succeed.
// R2 - Health lamp steady on when powered but otherwise not operating normally.
// R3 - Health lamp off when transfers fail, host programming or faulted; the code does not darken it on diag_fault.
// R4 - Fault lamp off without diagnostic problem, steady on once one is found.
// R5 - Setup lamp off with no configuration activity and no configuration error.
// R6 - Setup lamp blinks once per configuration block carrying identifier 255; the code queues at most one more blink while a blink runs.
// R7 - Setup lamp steady on while port or system configuration error exists.
// R8 - Backplane lamp on when transfers failed, off while they proceed.
// R9 - First variant never lights the backplane lamp.
// R10 - Port error lamp off while that port transfers without errors.
// R11 - Port error lamp blinks while sporadic communication errors occur.
// R12 - Port error lamp steady on with port or system configuration error.
// R13 - Port error lamp steady on while its CTS input is not asserted.
// R14 - Port error lamp steady on when slave communication fails.
// R15 - Port error lamp steady on when master errors recur.
// R16 - First variant blinks the send lamp while the port transmits.
// R17 - First variant blinks the receive lamp while the port receives.
// R18 - Second variant blinks one traffic lamp while the port sends or receives.
// R19 - Fast and normal blink rates come from parameterised clock prescalers.
// R20 - Single-event blinks last at least one full visible on-off period.
`timescale 1ns/1ns
`default_nettype none
`include "slsl_params.svh"

module slsl_lamps #(
  parameter int unsigned FAST_HALF_CYC = `SLSL_FAST_HALF_CYC,
  parameter int unsigned SLOW_RATIO = `SLSL_SLOW_RATIO,
  parameter int unsigned PORTS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SLSL_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xfer_ok,
  input wire logic xfer_fail,
  input wire logic host_program_state,
  input wire logic diag_fault,
  input wire logic cfg_blk_valid,
  input wire logic [7:0] cfg_blk_id,
  input wire logic port_cfg_err,
  input wire logic sys_cfg_err,
  input wire slsl_pkg::slsl_port_t cts_pin,
  input wire slsl_pkg::slsl_port_t comm_err_event,
  input wire slsl_pkg::slsl_port_t slave_comm_fail,
  input wire slsl_pkg::slsl_port_t master_err_recur,
  input wire slsl_pkg::slsl_port_t tx_active,
  input wire slsl_pkg::slsl_port_t rx_active,
  output logic transfer_health_lamp,
  output logic fault_lamp,
  output logic setup_lamp,
  output logic backplane_failure_lamp,
  output logic port1_fault_lamp,
  output logic port2_fault_lamp,
  output logic port1_send_lamp,
  output logic port2_send_lamp,
  output logic port1_receive_lamp,
  output logic port2_receive_lamp,
  output logic port1_traffic_lamp,
  output logic port2_traffic_lamp
);
  import slsl_pkg::*;

  localparam int unsigned FAST_W = $clog2(FAST_HALF_CYC + 1);
  localparam int unsigned SLOW_W = $clog2(SLOW_RATIO + 1);
  localparam logic [FAST_W-1:0] FAST_LAST = FAST_W'(FAST_HALF_CYC - 1);
  localparam logic [SLOW_W-1:0] SLOW_LAST = SLOW_W'(SLOW_RATIO - 1);
  // Two slow half periods make one full visible blink
  localparam logic [1:0] HOLD_TICKS = 2'h2;

  logic [1:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic [FAST_W-1:0] fast_cnt_reg;
  logic [SLOW_W-1:0] slow_cnt_reg;
  logic fast_phase_reg;
  logic slow_phase_reg;
  logic fast_tick;
  logic slow_tick;
  slsl_port_t cts_meta_reg;
  slsl_port_t cts_sync_reg;
  slsl_setup_e setup_state_reg;
  slsl_setup_e setup_next;
  logic setup_pend_reg;
  logic setup_hit;
  logic [1:0] err_hold_reg [PORTS];
  logic [1:0] tx_hold_reg [PORTS];
  logic [1:0] rx_hold_reg [PORTS];
  logic cfg_err;
  logic combined;
  logic health_next;
  logic setup_next_lamp;
  logic bplane_next;
  slsl_port_t perr_next;
  slsl_port_t send_next;
  slsl_port_t recv_next;
  slsl_port_t traf_next;
  logic apb_write;
  logic [11:0] lamp_vec;

  // Reloads an activity hold to a full period or counts it down on slow ticks
  function automatic logic [1:0] hold_step(
    input logic [1:0] cur,
    input logic event_in,
    input logic tick
  );
    logic [1:0] nxt;
    nxt = cur;
    if (event_in)
    begin
      nxt = HOLD_TICKS;
    end
    else if (tick && (cur != 2'h0))
    begin
      nxt = cur - 2'h1;
    end
    return nxt;
  endfunction

  function automatic logic addr_known(input logic [`SLSL_ADDR_W-1:0] a);
    return (a == `SLSL_OFS_CTRL) || (a == `SLSL_OFS_STATUS) ||
      (a == `SLSL_OFS_INPUTS);
  endfunction

  assign combined = ctrl_reg[`SLSL_CTRL_VARIANT];
  assign cfg_err = port_cfg_err | sys_cfg_err;

  // APB slave: zero wait states while enabled; a frozen block holds the access
  assign pready = clk_en;
  assign pslverr = psel & penable & ~addr_known(paddr);
  assign prdata = prdata_reg;
  assign apb_write = psel & penable & pwrite & clk_en;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `SLSL_CTRL_RESET;
    end
    else if (apb_write && (paddr == `SLSL_OFS_CTRL))
    begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  // Read data is captured in the setup cycle so it is stable for the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0;
    end
    else if (clk_en && psel && !penable)
    begin
      prdata_reg <= 32'h0;
      if (!pwrite)
      begin
        unique case (paddr)
          `SLSL_OFS_CTRL: prdata_reg[1:0] <= ctrl_reg;
          `SLSL_OFS_STATUS: prdata_reg[11:0] <= lamp_vec;
          `SLSL_OFS_INPUTS: prdata_reg[1:0] <= cts_sync_reg;
          default: prdata_reg <= 32'h0;
        endcase
      end
    end
  end

  // CTS pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cts_meta_reg <= 2'h0;
      cts_sync_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      cts_meta_reg <= cts_pin;
      cts_sync_reg <= cts_meta_reg;
    end
  end

  // Blink prescalers; slow rate is a whole multiple of the fast one
  assign fast_tick = (fast_cnt_reg == FAST_LAST);
  assign slow_tick = fast_tick && (slow_cnt_reg == SLOW_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_cnt_reg <= '0;
      slow_cnt_reg <= '0;
      fast_phase_reg <= 1'b0;
      slow_phase_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      fast_cnt_reg <= fast_tick ? '0 : fast_cnt_reg + FAST_W'(1); // R19
      if (fast_tick)
      begin
        fast_phase_reg <= ~fast_phase_reg; // R19
        slow_cnt_reg <= (slow_cnt_reg == SLOW_LAST) ? '0 : slow_cnt_reg + SLOW_W'(1);
      end
      if (slow_tick)
      begin
        slow_phase_reg <= ~slow_phase_reg; // R19
      end
    end
  end

  // Setup lamp single blink sequencer
  assign setup_hit = cfg_blk_valid && (cfg_blk_id == `SLSL_SETUP_BLOCK_ID); // R6

  always_comb
  begin
    setup_next = setup_state_reg;
    unique case (setup_state_reg)
      SLSL_SETUP_IDLE:
      begin
        if (setup_hit || setup_pend_reg)
        begin
          setup_next = SLSL_SETUP_ARM;
        end
      end
      // Align to a tick so the on half is never cut short
      SLSL_SETUP_ARM:
      begin
        if (slow_tick)
        begin
          setup_next = SLSL_SETUP_ON; // R20
        end
      end
      SLSL_SETUP_ON:
      begin
        if (slow_tick)
        begin
          setup_next = SLSL_SETUP_OFF; // R20
        end
      end
      SLSL_SETUP_OFF:
      begin
        if (slow_tick)
        begin
          setup_next = SLSL_SETUP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      setup_state_reg <= SLSL_SETUP_IDLE;
    end
    else if (clk_en)
    begin
      setup_state_reg <= setup_next;
    end
  end

  // A block arriving mid-blink queues one more blink; one arriving as the queued blink is taken is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      setup_pend_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (setup_hit && (setup_state_reg != SLSL_SETUP_IDLE))
      begin
        setup_pend_reg <= 1'b1; // R6
      end
      else if (setup_state_reg == SLSL_SETUP_IDLE)
      begin
        setup_pend_reg <= 1'b0;
      end
    end
  end

  // Per-port activity and error holds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < PORTS; i++)
      begin
        err_hold_reg[i] <= 2'h0;
        tx_hold_reg[i] <= 2'h0;
        rx_hold_reg[i] <= 2'h0;
      end
    end
    else if (clk_en)
    begin
      for (int i = 0; i < PORTS; i++)
      begin
        err_hold_reg[i] <= hold_step(err_hold_reg[i], comm_err_event[i], slow_tick); // R11
        tx_hold_reg[i] <= hold_step(tx_hold_reg[i], tx_active[i], slow_tick); // R20
        rx_hold_reg[i] <= hold_step(rx_hold_reg[i], rx_active[i], slow_tick); // R20
      end
    end
  end

  // Lamp decisions
  always_comb
  begin
    if (xfer_fail || host_program_state)
    begin
      health_next = 1'b0; // R3
    end
    else if (xfer_ok)
    begin
      health_next = fast_phase_reg; // R1
    end
    else
    begin
      health_next = 1'b1; // R2
    end
    if (cfg_err)
    begin
      setup_next_lamp = 1'b1; // R7
    end
    else
    begin
      setup_next_lamp = (setup_state_reg == SLSL_SETUP_ON); // R5 R6
    end
    bplane_next = combined && (xfer_fail || host_program_state); // R8 R9
    for (int i = 0; i < PORTS; i++)
    begin
      if (cfg_err || !cts_sync_reg[i] || slave_comm_fail[i] || master_err_recur[i])
      begin
        perr_next[i] = 1'b1; // R12 R13 R14 R15
      end
      else if (err_hold_reg[i] != 2'h0)
      begin
        perr_next[i] = slow_phase_reg; // R11
      end
      else
      begin
        perr_next[i] = 1'b0; // R10
      end
      send_next[i] = !combined && (tx_hold_reg[i] != 2'h0) && fast_phase_reg; // R16
      recv_next[i] = !combined && (rx_hold_reg[i] != 2'h0) && fast_phase_reg; // R17
      traf_next[i] = combined && fast_phase_reg &&
        ((tx_hold_reg[i] != 2'h0) || (rx_hold_reg[i] != 2'h0)); // R18
    end
  end

  // Lamp outputs are registered so a changing cause never glitches a lamp
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transfer_health_lamp <= 1'b0;
      fault_lamp <= 1'b0;
      setup_lamp <= 1'b0;
      backplane_failure_lamp <= 1'b0;
      port1_fault_lamp <= 1'b0;
      port2_fault_lamp <= 1'b0;
      port1_send_lamp <= 1'b0;
      port2_send_lamp <= 1'b0;
      port1_receive_lamp <= 1'b0;
      port2_receive_lamp <= 1'b0;
      port1_traffic_lamp <= 1'b0;
      port2_traffic_lamp <= 1'b0;
    end
    else if (clk_en)
    begin
      transfer_health_lamp <= health_next;
      fault_lamp <= diag_fault; // R4
      setup_lamp <= setup_next_lamp;
      backplane_failure_lamp <= bplane_next; // R9
      port1_fault_lamp <= perr_next[0];
      port2_fault_lamp <= perr_next[1];
      port1_send_lamp <= send_next[0];
      port2_send_lamp <= send_next[1];
      port1_receive_lamp <= recv_next[0];
      port2_receive_lamp <= recv_next[1];
      port1_traffic_lamp <= traf_next[0];
      port2_traffic_lamp <= traf_next[1];
    end
  end

  assign lamp_vec = {port2_traffic_lamp, port1_traffic_lamp, port2_receive_lamp,
    port1_receive_lamp, port2_send_lamp, port1_send_lamp, port2_fault_lamp, port1_fault_lamp,
    backplane_failure_lamp, setup_lamp, fault_lamp, transfer_health_lamp};

endmodule // slsl_lamps
`default_nettype wire

// >>> slsl_lamps_props.sv
// Checker for the status lamp block: lamp relations at the top ports.
// Assumes it is bound into slsl_lamps; lamps are registered one edge after cause, CTS-driven port lamps three edges after the pin.
`timescale 1ns/1ns
`default_nettype none

module slsl_lamps_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic xfer_ok,
  input wire logic xfer_fail,
  input wire logic host_program_state,
  input wire logic diag_fault,
  input wire logic port_cfg_err,
  input wire logic sys_cfg_err,
  input wire slsl_pkg::slsl_port_t cts_pin,
  input wire slsl_pkg::slsl_port_t slave_comm_fail,
  input wire slsl_pkg::slsl_port_t master_err_recur,
  input wire logic transfer_health_lamp,
  input wire logic fault_lamp,
  input wire logic setup_lamp,
  input wire logic backplane_failure_lamp,
  input wire logic port1_fault_lamp,
  input wire logic port2_fault_lamp
);
  import slsl_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_health_dark: assert property (
    clk_en && (xfer_fail || host_program_state) |=> !transfer_health_lamp)
    else $error("health lamp lit during failure");
  chk_health_steady: assert property (
    clk_en && !xfer_fail && !host_program_state && !xfer_ok |=> transfer_health_lamp)
    else $error("health lamp not steady");
  chk_fault_on: assert property (clk_en && diag_fault |=> fault_lamp)
    else $error("fault lamp dark");
  chk_fault_off: assert property (clk_en && !diag_fault |=> !fault_lamp)
    else $error("fault lamp lit");
  chk_setup_err: assert property (
    clk_en && (port_cfg_err || sys_cfg_err) |=> setup_lamp)
    else $error("setup lamp dark on config error");
  chk_bplane_cause: assert property (
    $past(clk_en) && backplane_failure_lamp |-> $past(xfer_fail || host_program_state))
    else $error("backplane lamp without failure");
  chk_port_cfg: assert property (
    clk_en && (port_cfg_err || sys_cfg_err) |=> port1_fault_lamp && port2_fault_lamp)
    else $error("port lamps dark on config error");
  chk_cts_missing: assert property ((clk_en && !cts_pin[1])[*3] |=> port2_fault_lamp)
    else $error("port lamp dark without handshake");
  chk_slave_fail: assert property (clk_en && slave_comm_fail[0] |=> port1_fault_lamp)
    else $error("port lamp dark on slave failure");
  chk_master_recur: assert property (clk_en && master_err_recur[1] |=> port2_fault_lamp)
    else $error("port lamp dark on recurring error");

  cover property ($rose(setup_lamp));
  cover property (xfer_ok ##1 $fell(transfer_health_lamp));
  cover property ($rose(backplane_failure_lamp));
endmodule // slsl_lamps_props
`default_nettype wire

// >>> slsl_host_model.sv
// Host controller model: block transfer health and configuration blocks.
// Assumes the bench sets mode and requests blocks just after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module slsl_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic cfg_req,
  input wire logic [7:0] cfg_id,
  output logic xfer_ok,
  output logic xfer_fail,
  output logic host_program_state,
  output logic cfg_blk_valid,
  output logic [7:0] cfg_blk_id
);
  // Mode 0 runs, 1 fails, 2 programs, 3 makes no transfers at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xfer_ok <= 1'b0;
      xfer_fail <= 1'b0;
      host_program_state <= 1'b0;
      cfg_blk_valid <= 1'b0;
      cfg_blk_id <= 8'h00;
    end
    else
    begin
      xfer_ok <= mode == 2'd0;
      xfer_fail <= mode == 2'd1;
      host_program_state <= mode == 2'd2;
      cfg_blk_valid <= cfg_req;
      // Idle id toggles so no stale value looks valid
      cfg_blk_id <= cfg_req ? cfg_id : ~cfg_blk_id;
    end
  end
endmodule // slsl_host_model
`default_nettype wire

// >>> slsl_lamps_test.sv
// Testbench for the status lamp block: APB access and lamp scenarios.
// Assumes slsl_pkg, slsl_lamps, the host model and the checker compile first.
`timescale 1ns/1ns
`default_nettype none

module slsl_lamps_test;
  import slsl_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, err, cfg_req;
  logic diag_fault, port_cfg_err, sys_cfg_err;
  logic [7:0] paddr, cfg_id;
  logic [31:0] pwdata, rd;
  logic [1:0] mode;
  slsl_port_t cts_pin, comm_err_event, slave_comm_fail, master_err_recur, tx_active, rx_active;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, xfer_ok, xfer_fail, host_program_state, cfg_blk_valid;
  wire logic [7:0] cfg_blk_id;
  wire logic transfer_health_lamp, fault_lamp, setup_lamp, backplane_failure_lamp;
  wire logic port1_fault_lamp, port2_fault_lamp, port1_send_lamp, port2_send_lamp;
  wire logic port1_receive_lamp, port2_receive_lamp, port1_traffic_lamp, port2_traffic_lamp;
  wire logic [11:0] lamps;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int hi;

  assign lamps = {port2_traffic_lamp, port1_traffic_lamp, port2_receive_lamp,
    port1_receive_lamp, port2_send_lamp, port1_send_lamp, port2_fault_lamp, port1_fault_lamp,
    backplane_failure_lamp, setup_lamp, fault_lamp, transfer_health_lamp};

  slsl_host_model slsl_host_model_i (.pclk, .presetn, .mode, .cfg_req, .cfg_id, .xfer_ok,
    .xfer_fail, .host_program_state, .cfg_blk_valid, .cfg_blk_id);
  // Short blink counts: fast half 4 cycles, slow half 8 cycles
  slsl_lamps #(.FAST_HALF_CYC(4), .SLOW_RATIO(2)) slsl_lamps_i (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .xfer_ok, .xfer_fail,
    .host_program_state, .diag_fault, .cfg_blk_valid, .cfg_blk_id, .port_cfg_err, .sys_cfg_err,
    .cts_pin, .comm_err_event, .slave_comm_fail, .master_err_recur, .tx_active, .rx_active,
    .transfer_health_lamp, .fault_lamp, .setup_lamp, .backplane_failure_lamp, .port1_fault_lamp,
    .port2_fault_lamp, .port1_send_lamp, .port2_send_lamp, .port1_receive_lamp,
    .port2_receive_lamp, .port1_traffic_lamp, .port2_traffic_lamp);

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task measure(input int idx, input int n);
    hi = 0;
    repeat (n)
    begin
      @(negedge pclk);
      hi += lamps[idx];
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Waits as long as the slave stalls; only the bench timeout ends a hang
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task blk(input logic [7:0] id, input int n);
    @(posedge pclk);
    cfg_req <= 1'b1;
    cfg_id <= id;
    repeat (n) @(posedge pclk);
    cfg_req <= 1'b0;
  endtask

  task t_regs;
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0, "control reset value");
    check(err, 1'b0, "mapped read accepted");
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h3, "handshake readback");
    apb(1'b0, 8'h0c, 32'h0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
  endtask

  task t_health;
    @(posedge pclk);
    mode <= 2'd1;
    settle(3);
    check(transfer_health_lamp, 1'b0, "health on failure");
    check(backplane_failure_lamp, 1'b0, "backplane in split variant");
    @(posedge pclk);
    mode <= 2'd2;
    settle(3);
    check(transfer_health_lamp, 1'b0, "health in program mode");
    @(posedge pclk);
    mode <= 2'd3;
    settle(3);
    measure(0, 32);
    check(hi, 32, "health steady");
    @(posedge pclk);
    mode <= 2'd0;
    settle(3);
    measure(0, 32);
    check(hi, 16, "health fast blink");
  endtask

  task t_fault;
    @(posedge pclk);
    diag_fault <= 1'b1;
    settle(2);
    check(fault_lamp, 1'b1, "fault lit");
    apb(1'b0, 8'h04, 32'h0);
    check(rd[1], 1'b1, "status shows fault");
    @(posedge pclk);
    diag_fault <= 1'b0;
    settle(2);
    check(fault_lamp, 1'b0, "fault dark");
  endtask

  task t_freeze;
    @(posedge pclk);
    clk_en <= 1'b0;
    diag_fault <= 1'b1;
    settle(3);
    check(fault_lamp, 1'b0, "frozen lamp holds");
    check(pready, 1'b0, "frozen bus stalls");
    @(posedge pclk);
    clk_en <= 1'b1;
    settle(2);
    check(fault_lamp, 1'b1, "fault lit after freeze");
    @(posedge pclk);
    diag_fault <= 1'b0;
    settle(2);
  endtask

  task t_setup;
    blk(8'h10, 1);
    measure(2, 48);
    check(hi, 0, "other block ignored");
    blk(8'hff, 1);
    measure(2, 48);
    check(hi, 8, "single setup blink");
    blk(8'hff, 2);
    measure(2, 64);
    check(hi, 16, "two setup blinks");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      {sys_cfg_err, port_cfg_err} <= 2'b01 << i;
      settle(2);
      measure(2, 16);
      check(hi, 16, "setup steady on error");
      check({port2_fault_lamp, port1_fault_lamp}, 2'b11, "port lamps on error");
    end
    @(posedge pclk);
    sys_cfg_err <= 1'b0;
  endtask

  task t_ports;
    @(posedge pclk);
    tx_active <= 2'b11;
    settle(40);
    check({port2_fault_lamp, port1_fault_lamp}, 2'b00, "clean traffic");
    fork
      repeat (12)
      begin
        @(posedge pclk);
        comm_err_event <= 2'b01;
        @(posedge pclk);
        comm_err_event <= 2'b00;
        repeat (2) @(posedge pclk);
      end
      begin
        settle(8);
        measure(4, 32);
      end
    join
    check(hi, 16, "sporadic error blink");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      cts_pin <= 2'b10 >> i;
      slave_comm_fail <= 2'b00;
      master_err_recur <= 2'b00;
      settle(8);
      check({port2_fault_lamp, port1_fault_lamp}, 2'b01 << i, "missing handshake");
      @(posedge pclk);
      cts_pin <= 2'b11;
      slave_comm_fail <= 2'b10 >> i;
      master_err_recur <= 2'b01 << i;
      settle(4);
      check(lamps[5 - i], 1'b1, "slave failure");
      check(lamps[4 + i], 1'b1, "recurring master error");
    end
    @(posedge pclk);
    slave_comm_fail <= 2'b00;
    master_err_recur <= 2'b00;
  endtask

  task t_traffic;
    @(posedge pclk);
    tx_active <= 2'b01;
    rx_active <= 2'b10;
    settle(4);
    measure(6, 32);
    check(hi, 16, "send blink");
    measure(9, 32);
    check(hi, 16, "receive blink");
    measure(7, 32);
    check(hi, 0, "idle send lamp");
    measure(10, 32);
    check(hi, 0, "no traffic lamp when split");
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1, "variant readback");
    settle(4);
    measure(10, 32);
    check(hi, 16, "traffic port one");
    measure(11, 32);
    check(hi, 16, "traffic port two");
    measure(6, 32);
    check(hi, 0, "no send lamp when combined");
    measure(9, 32);
    check(hi, 0, "no receive lamp when combined");
    @(posedge pclk);
    mode <= 2'd1;
    settle(3);
    check(backplane_failure_lamp, 1'b1, "backplane on failure");
    @(posedge pclk);
    mode <= 2'd0;
    settle(3);
    check(backplane_failure_lamp, 1'b0, "backplane clear");
  endtask

  task conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, cfg_req, diag_fault, port_cfg_err, sys_cfg_err} = 8'h00;
    {paddr, cfg_id, pwdata} = 48'h0;
    {comm_err_event, slave_comm_fail, master_err_recur, tx_active, rx_active} = 10'h0;
    clk_en = 1'b1;
    cts_pin = 2'b11;
    mode = 2'd3;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle(4);
    t_regs;
    t_health;
    t_fault;
    t_freeze;
    t_setup;
    t_ports;
    t_traffic;
    conclude;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      conclude;
    end
  end
endmodule // slsl_lamps_test

bind slsl_lamps slsl_lamps_props slsl_lamps_props_i (.pclk, .presetn, .clk_en, .xfer_ok,
  .xfer_fail, .host_program_state, .diag_fault, .port_cfg_err, .sys_cfg_err, .cts_pin,
  .slave_comm_fail, .master_err_recur, .transfer_health_lamp, .fault_lamp, .setup_lamp,
  .backplane_failure_lamp, .port1_fault_lamp, .port2_fault_lamp);
`default_nettype wire
